// file: hw/fisj_core.sv
// Execution core for file increment, decrement with skip, OR and absolute jump.
//
// Behaviour
// - Decrement-and-skip subtracts one from the file register, sends it to acc or file by d, flags untouched.
// - A zero decrement-and-skip result turns the next instruction into a no-operation, two cycles in all.
// - Increment-and-skip adds one to file register 0..127, routes it by d, flags untouched.
// - A zero increment-and-skip result runs a no-operation in place of the next instruction.
// - The absolute jump loads its 11-bit operand into pc bits 10..0 and page latch bits 4..3 into pc 12..11.
// - The absolute jump is unconditional, touches no flags and takes two instruction cycles.
// - OR-with-literal ORs the accumulator with the 8-bit literal into the accumulator and updates zero.
// - Plain increment adds one to the file register, routes it by d and updates zero.
// - OR-with-file ORs acc with the file register, routes it by d and updates zero.
`timescale 1ns/100ps
`default_nettype none
module fisj_core
  import fisj_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic [FISJ_LATCH_W-1:0] pc_page_latch_in,
  input  wire logic [FISJ_INSN_W-1:0]  prog_data_in,
  output var  logic [FISJ_PC_W-1:0]    prog_addr_out,
  output var  logic [FISJ_PC_W-1:0]    pc_out,
  output var  logic [FISJ_DATA_W-1:0]  acc_out,
  output var  logic                    zero_flag_out,
  output var  logic                    cycle_end_out,
  output var  logic                    nop_cycle_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fisj_phase_t             phase;
  fisj_phase_t             next_phase;
  logic [FISJ_INSN_W-1:0]  insn;
  logic [FISJ_INSN_W-1:0]  next_insn;
  logic [FISJ_PC_W-1:0]    pc;
  logic [FISJ_PC_W-1:0]    next_pc;
  logic [FISJ_PC_W-1:0]    next_prog_addr;
  logic [FISJ_DATA_W-1:0]  acc;
  logic [FISJ_DATA_W-1:0]  next_acc;
  logic                    zero_flag;
  logic                    next_zero_flag;
  logic                    next_cycle_end;
  logic                    nop_pending;
  logic                    next_nop_pending;
  logic                    nop_advance;
  logic                    next_nop_advance;
  logic                    next_nop_cycle;

  // ----------------------------------------------------------------
  // File memory
  // ----------------------------------------------------------------
  logic [FISJ_FADDR_W-1:0] ram_rd_addr;
  logic [FISJ_DATA_W-1:0]  ram_rd_data;
  logic                    ram_wr_en;
  logic [FISJ_DATA_W-1:0]  ram_wr_data;

  // The read is issued straight from the fetched word so the operand is
  // ready in the execute phase without an extra cycle.
  assign ram_rd_addr = (phase == FISJ_PH_LOAD) ? prog_data_in[FISJ_FADDR_W-1:0]
                                               : insn[FISJ_FADDR_W-1:0];

  fisj_file_ram u_file_ram (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .rd_addr_in  (ram_rd_addr),
    .rd_data_out (ram_rd_data),
    .wr_en_in    (ram_wr_en),
    .wr_addr_in  (insn[FISJ_FADDR_W-1:0]),
    .wr_data_in  (ram_wr_data)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [5:0]             op6;
  logic [2:0]             op3;
  logic                   dest_file;
  logic [FISJ_DATA_W-1:0] dec_val;
  logic [FISJ_DATA_W-1:0] inc_val;
  logic [FISJ_DATA_W-1:0] or_file_val;
  logic [FISJ_DATA_W-1:0] or_lit_val;

  assign op6         = insn[FISJ_OP6_LSB+5:FISJ_OP6_LSB];
  assign op3         = insn[FISJ_OP3_LSB+2:FISJ_OP3_LSB];
  assign dest_file   = insn[FISJ_DEST_BIT];
  assign dec_val     = ram_rd_data - FISJ_ONE;
  assign inc_val     = ram_rd_data + FISJ_ONE;
  assign or_file_val = acc | ram_rd_data;
  assign or_lit_val  = acc | insn[FISJ_DATA_W-1:0];

  // ----------------------------------------------------------------
  // Sequencer and execute
  // ----------------------------------------------------------------
  // Each instruction cycle is four clocks: address out, memory latency,
  // word capture with operand read, then execute and write back.
  always_comb begin
    next_phase       = phase;
    next_insn        = insn;
    next_pc          = pc;
    next_prog_addr   = prog_addr_out;
    next_acc         = acc;
    next_zero_flag   = zero_flag;
    next_nop_pending = nop_pending;
    next_nop_advance = nop_advance;
    next_nop_cycle   = nop_cycle_out;
    next_cycle_end   = 1'b0;
    ram_wr_en        = 1'b0;
    ram_wr_data      = FISJ_ZERO;
    case (phase)
      FISJ_PH_ADDR: begin
        next_prog_addr = pc;
        next_phase     = FISJ_PH_WAIT;
      end
      FISJ_PH_WAIT: begin
        next_phase = FISJ_PH_LOAD;
      end
      FISJ_PH_LOAD: begin
        next_insn  = prog_data_in;
        next_phase = FISJ_PH_EXEC;
      end
      FISJ_PH_EXEC: begin
        next_phase     = FISJ_PH_ADDR;
        next_cycle_end = 1'b1;
        next_nop_cycle = nop_pending;
        if (nop_pending) begin
          // Bubble cycle: the fetched word is discarded.
          next_nop_pending = 1'b0;
          if (nop_advance) begin
            next_pc = pc + FISJ_PC_STEP;
          end
        end else begin
          next_pc = pc + FISJ_PC_STEP;
          if (op6 == FISJ_OP_DECREMENT_SKIP_ZERO) begin
            if (dest_file) begin
              ram_wr_en   = 1'b1;
              ram_wr_data = dec_val;
            end else begin
              next_acc = dec_val;
            end
            if (dec_val == FISJ_ZERO) begin
              next_nop_pending = 1'b1;
              next_nop_advance = 1'b1;
            end
          end else if (op6 == FISJ_OP_INCREMENT_SKIP_ZERO) begin
            if (dest_file) begin
              ram_wr_en   = 1'b1;
              ram_wr_data = inc_val;
            end else begin
              next_acc = inc_val;
            end
            if (inc_val == FISJ_ZERO) begin
              next_nop_pending = 1'b1;
              next_nop_advance = 1'b1;
            end
          end else if (op6 == FISJ_OP_INCREMENT_FILE) begin
            if (dest_file) begin
              ram_wr_en   = 1'b1;
              ram_wr_data = inc_val;
            end else begin
              next_acc = inc_val;
            end
            next_zero_flag = (inc_val == FISJ_ZERO);
          end else if (op6 == FISJ_OP_OR_ACC_WITH_FILE) begin
            if (dest_file) begin
              ram_wr_en   = 1'b1;
              ram_wr_data = or_file_val;
            end else begin
              next_acc = or_file_val;
            end
            next_zero_flag = (or_file_val == FISJ_ZERO);
          end else if (op6 == FISJ_OP_OR_LITERAL_INTO_ACC) begin
            next_acc       = or_lit_val;
            next_zero_flag = (or_lit_val == FISJ_ZERO);
          end else if (op3 == FISJ_OP_ABSOLUTE_JUMP) begin
            next_pc = {pc_page_latch_in[FISJ_LATCH_HI:FISJ_LATCH_LO],
                       insn[FISJ_JUMP_W-1:0]};
            // The second cycle is a bubble that holds the new target.
            next_nop_pending = 1'b1;
            next_nop_advance = 1'b0;
          end
          // Any other word executes as a no-operation.
        end
      end
      default: begin
        next_phase = FISJ_PH_ADDR;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase         <= FISJ_PH_ADDR;
      insn          <= FISJ_INSN_RESET;
      pc            <= FISJ_PC_RESET;
      prog_addr_out <= FISJ_PC_RESET;
      acc           <= FISJ_ACC_RESET;
      zero_flag     <= 1'b0;
      nop_pending   <= 1'b0;
      nop_advance   <= 1'b0;
      nop_cycle_out <= 1'b0;
      cycle_end_out <= 1'b0;
    end else begin
      phase         <= next_phase;
      insn          <= next_insn;
      pc            <= next_pc;
      prog_addr_out <= next_prog_addr;
      acc           <= next_acc;
      zero_flag     <= next_zero_flag;
      nop_pending   <= next_nop_pending;
      nop_advance   <= next_nop_advance;
      nop_cycle_out <= next_nop_cycle;
      cycle_end_out <= next_cycle_end;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pc_out        = pc;
  assign acc_out       = acc;
  assign zero_flag_out = zero_flag;

endmodule : fisj_core
`default_nettype wire

// file: hw/fisj_file_ram.sv
// File register memory with registered read data and synchronous write.
`timescale 1ns/100ps
`default_nettype none
module fisj_file_ram
  import fisj_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic [FISJ_FADDR_W-1:0] rd_addr_in,
  output var  logic [FISJ_DATA_W-1:0]  rd_data_out,
  input  wire logic                    wr_en_in,
  input  wire logic [FISJ_FADDR_W-1:0] wr_addr_in,
  input  wire logic [FISJ_DATA_W-1:0]  wr_data_in
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Contents are not cleared by reset, like ordinary data memory.
  logic [FISJ_DATA_W-1:0] mem [2**FISJ_FADDR_W];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= FISJ_ZERO;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule : fisj_file_ram
`default_nettype wire

// file: hw/fisj_pkg.sv
// Constants and types shared by the file increment, skip and jump core.
package fisj_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int FISJ_PC_W    = 13;
  localparam int FISJ_DATA_W  = 8;
  localparam int FISJ_FADDR_W = 7;
  localparam int FISJ_INSN_W  = 14;
  localparam int FISJ_JUMP_W  = 11;
  localparam int FISJ_LATCH_W = 5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FISJ_DEST_BIT   = 7;
  localparam int FISJ_OP6_LSB    = 8;
  localparam int FISJ_OP3_LSB    = 11;
  localparam int FISJ_LATCH_HI   = 4;
  localparam int FISJ_LATCH_LO   = 3;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [5:0] FISJ_OP_DECREMENT_SKIP_ZERO  = 6'h0b;
  localparam logic [5:0] FISJ_OP_INCREMENT_SKIP_ZERO  = 6'h0f;
  localparam logic [5:0] FISJ_OP_INCREMENT_FILE       = 6'h0a;
  localparam logic [5:0] FISJ_OP_OR_ACC_WITH_FILE     = 6'h04;
  localparam logic [5:0] FISJ_OP_OR_LITERAL_INTO_ACC  = 6'h38;
  localparam logic [2:0] FISJ_OP_ABSOLUTE_JUMP        = 3'h5;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [FISJ_PC_W-1:0]   FISJ_PC_RESET   = 13'h0000;
  localparam logic [FISJ_DATA_W-1:0] FISJ_ACC_RESET  = 8'h00;
  localparam logic [FISJ_DATA_W-1:0] FISJ_ONE        = 8'h01;
  localparam logic [FISJ_DATA_W-1:0] FISJ_ZERO       = 8'h00;
  localparam logic [FISJ_PC_W-1:0]   FISJ_PC_STEP    = 13'h0001;
  localparam logic [FISJ_INSN_W-1:0] FISJ_INSN_RESET = 14'h0000;
  localparam int                     FISJ_PHASES     = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FISJ_PH_ADDR,
    FISJ_PH_WAIT,
    FISJ_PH_LOAD,
    FISJ_PH_EXEC
  } fisj_phase_t;

endpackage : fisj_pkg

// file: verif/fisj_core_assertions.sv
// Concurrent checks on the ports of the execution core.
`timescale 1ns/100ps
`default_nettype none
module fisj_core_assertions
  import fisj_pkg::*;
(
  input wire logic                    clk_in,
  input wire logic                    rst_in,
  input wire logic [FISJ_LATCH_W-1:0] pc_page_latch_in,
  input wire logic [FISJ_INSN_W-1:0]  prog_data_in,
  input wire logic [FISJ_PC_W-1:0]    prog_addr_out,
  input wire logic [FISJ_PC_W-1:0]    pc_out,
  input wire logic [FISJ_DATA_W-1:0]  acc_out,
  input wire logic                    zero_flag_out,
  input wire logic                    cycle_end_out,
  input wire logic                    nop_cycle_out
);
  // ----------------------------------------------------------------
  // Word seen in the load phase and latch seen at execute.
  // ----------------------------------------------------------------
  logic [FISJ_INSN_W-1:0]  w1;
  logic [FISJ_INSN_W-1:0]  w2;
  logic [FISJ_LATCH_W-1:0] lt;
  logic                    ex;
  logic                    skp;
  logic                    jmp;
  logic                    orl;
  logic                    zop;

  always_ff @(posedge clk_in) begin
    w1 <= prog_data_in;
    w2 <= w1;
    lt <= pc_page_latch_in;
  end

  assign ex  = cycle_end_out && !nop_cycle_out;
  assign skp = (w2[13:8] == FISJ_OP_DECREMENT_SKIP_ZERO) ||
               (w2[13:8] == FISJ_OP_INCREMENT_SKIP_ZERO);
  assign jmp = w2[13:11] == FISJ_OP_ABSOLUTE_JUMP;
  assign orl = w2[13:8] == FISJ_OP_OR_LITERAL_INTO_ACC;
  assign zop = ((w2[13:8] == FISJ_OP_INCREMENT_FILE) ||
                (w2[13:8] == FISJ_OP_OR_ACC_WITH_FILE)) && !w2[FISJ_DEST_BIT];

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_next(n);
    ##4 (cycle_end_out && (nop_cycle_out == n));
  endsequence

  property p_cycle;
    cycle_end_out |=> !cycle_end_out [*3] ##1 cycle_end_out;
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle end spacing wrong");

  property p_skip_taken;
    ex && skp && !w2[FISJ_DEST_BIT] && (acc_out == FISJ_ZERO) |-> s_next(1'b1);
  endproperty
  a_skip_taken: assert property (p_skip_taken) else $error("zero skip no bubble");

  property p_skip_not;
    ex && skp && !w2[FISJ_DEST_BIT] && (acc_out != FISJ_ZERO) |-> s_next(1'b0);
  endproperty
  a_skip_not: assert property (p_skip_not) else $error("nonzero skip bubbled");

  property p_flags;
    ex && (skp || jmp) |-> zero_flag_out == $past(zero_flag_out, 4);
  endproperty
  a_flags: assert property (p_flags) else $error("zero flag moved");

  property p_jump_pc;
    ex && jmp |-> pc_out == {lt[FISJ_LATCH_HI:FISJ_LATCH_LO], w2[10:0]};
  endproperty
  a_jump_pc: assert property (p_jump_pc) else $error("jump target wrong");

  property p_jump_bubble;
    ex && jmp |-> s_next(1'b1) and ##4 (pc_out == $past(pc_out, 4));
  endproperty
  a_jump_bubble: assert property (p_jump_bubble) else $error("jump not two cycles");

  property p_or_lit;
    ex && orl |-> (acc_out == ($past(acc_out, 4) | w2[7:0])) &&
                  (zero_flag_out == (acc_out == FISJ_ZERO));
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("literal OR wrong");

  property p_zero;
    ex && zop |-> zero_flag_out == (acc_out == FISJ_ZERO);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_pc_step;
    ex && !jmp |-> pc_out == $past(pc_out, 4) + FISJ_PC_STEP;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc did not step");

  property p_fetch_addr;
    cycle_end_out |=> prog_addr_out == $past(pc_out);
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong");
endmodule : fisj_core_assertions

bind fisj_core fisj_core_assertions u_chk (.clk_in, .rst_in, .pc_page_latch_in,
  .prog_data_in, .prog_addr_out, .pc_out, .acc_out, .zero_flag_out, .cycle_end_out,
  .nop_cycle_out);
`default_nettype wire

// file: verif/fisj_core_bench.sv
// Self-checking bench for the execution core.
`timescale 1ns/100ps
`default_nettype none
module fisj_core_bench;
  import fisj_pkg::*;
  localparam logic [5:0] ORL = FISJ_OP_OR_LITERAL_INTO_ACC;
  localparam logic [5:0] ORF = FISJ_OP_OR_ACC_WITH_FILE;
  localparam logic [5:0] INC = FISJ_OP_INCREMENT_FILE;
  localparam logic [5:0] ISK = FISJ_OP_INCREMENT_SKIP_ZERO;
  localparam logic [5:0] DSK = FISJ_OP_DECREMENT_SKIP_ZERO;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [4:0]  latch  = 5'h0c;
  logic [13:0] word;
  logic [12:0] addr;
  logic [12:0] pc;
  logic [7:0]  acc;
  logic        z;
  logic        ce;
  logic        nop;
  int          failures = 0;
  int          checked = 0;

  initial forever #4 clk_in = ~clk_in;

  fisj_prog_mem pm (.clk_in, .addr_in(addr), .data_out(word));
  fisj_core dut (.clk_in, .rst_in, .pc_page_latch_in(latch), .prog_data_in(word),
    .prog_addr_out(addr), .pc_out(pc), .acc_out(acc), .zero_flag_out(z),
    .cycle_end_out(ce), .nop_cycle_out(nop));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Program is loaded under reset, so the core never fetches a half-written image.
  task automatic load(input logic [13:0] prog [$]);
    rst_in = 1'b1;
    for (int i = 0; i < (1 << FISJ_PC_W); i++) pm.mem[i] = 14'h0000;
    foreach (prog[i]) pm.mem[i] = prog[i];
    repeat (2) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
  endtask : load

  task automatic step(input logic [7:0] e_acc, input logic e_z, input logic [12:0] e_pc,
                      input logic e_nop);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (ce !== 1'b1 && n < 12);
    if (ce !== 1'b1) begin
      failures++;
      end_of_test();
    end else begin
      check({1'b0, acc, z, pc, nop}, {1'b0, e_acc, e_z, e_pc, e_nop});
    end
  endtask : step

  task automatic test_or_inc();
    load('{{ORL, 8'h00}, {ORL, 8'hff}, {ORF, 8'h90}, {INC, 8'h10}, {INC, 8'h90},
           {INC, 8'h10}, {ORF, 8'h10}});
    step(8'h00, 1'b1, 13'h1, 1'b0);
    step(8'hff, 1'b0, 13'h2, 1'b0);
    step(8'hff, 1'b0, 13'h3, 1'b0);
    step(8'h00, 1'b1, 13'h4, 1'b0);
    step(8'h00, 1'b1, 13'h5, 1'b0);
    step(8'h01, 1'b0, 13'h6, 1'b0);
    step(8'h01, 1'b0, 13'h7, 1'b0);
    $display("or_inc done");
  endtask : test_or_inc

  task automatic test_skip();
    load('{{ORL, 8'hff}, {ORF, 8'ha0}, {ISK, 8'h20}, {ORL, 8'h01}, {DSK, 8'ha0},
           {DSK, 8'h20}, {ORL, 8'h02}});
    step(8'hff, 1'b0, 13'h1, 1'b0);
    step(8'hff, 1'b0, 13'h2, 1'b0);
    step(8'h00, 1'b0, 13'h3, 1'b0);
    step(8'h00, 1'b0, 13'h4, 1'b1);
    step(8'h00, 1'b0, 13'h5, 1'b0);
    step(8'hfd, 1'b0, 13'h6, 1'b0);
    step(8'hff, 1'b0, 13'h7, 1'b0);
    $display("skip done");
  endtask : test_skip

  task automatic test_dec_zero();
    load('{{ORL, 8'hff}, {ORF, 8'hb0}, {INC, 8'hb0}, {INC, 8'hb0}, {DSK, 8'h30},
           {ORL, 8'h80}, {ORL, 8'h00}, {ORL, 8'hff}, {ORF, 8'hb0}, {ISK, 8'hb0},
           {INC, 8'hb0}, {INC, 8'h30}});
    step(8'hff, 1'b0, 13'h1, 1'b0);
    step(8'hff, 1'b0, 13'h2, 1'b0);
    step(8'hff, 1'b1, 13'h3, 1'b0);
    step(8'hff, 1'b0, 13'h4, 1'b0);
    step(8'h00, 1'b0, 13'h5, 1'b0);
    step(8'h00, 1'b0, 13'h6, 1'b1);
    step(8'h00, 1'b1, 13'h7, 1'b0);
    step(8'hff, 1'b0, 13'h8, 1'b0);
    step(8'hff, 1'b0, 13'h9, 1'b0);
    step(8'hff, 1'b0, 13'ha, 1'b0);
    step(8'hff, 1'b0, 13'hb, 1'b1);
    step(8'h01, 1'b0, 13'hc, 1'b0);
    $display("dec_zero done");
  endtask : test_dec_zero

  // Back-to-back jumps, with the latch changed between them.
  task automatic test_jump();
    latch = 5'h0c;
    load('{{FISJ_OP_ABSOLUTE_JUMP, 11'h7ff}, {ORL, 8'hff}});
    pm.mem[13'h0fff] = {FISJ_OP_ABSOLUTE_JUMP, 11'h010};
    pm.mem[13'h1010] = {ORL, 8'h3c};
    step(8'h00, 1'b0, 13'h0fff, 1'b0);
    step(8'h00, 1'b0, 13'h0fff, 1'b1);
    latch = 5'h14;
    step(8'h00, 1'b0, 13'h1010, 1'b0);
    step(8'h00, 1'b0, 13'h1010, 1'b1);
    step(8'h3c, 1'b0, 13'h1011, 1'b0);
    $display("jump done");
  endtask : test_jump

  initial begin
    repeat (16) @(posedge clk_in);
    #1;
    test_or_inc();
    test_skip();
    test_dec_zero();
    test_jump();
    end_of_test();
  end
endmodule : fisj_core_bench
`default_nettype wire

// file: verif/fisj_prog_mem.sv
// Program memory model feeding instruction words to the core.
`timescale 1ns/100ps
`default_nettype none
module fisj_prog_mem
  import fisj_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic [FISJ_PC_W-1:0]   addr_in,
  output var  logic [FISJ_INSN_W-1:0] data_out
);
  logic [FISJ_INSN_W-1:0] mem [0:(1<<FISJ_PC_W)-1];

  // One clock of read latency, so a word is valid only from the load phase on.
  always_ff @(posedge clk_in) begin
    data_out <= mem[addr_in];
  end
endmodule : fisj_prog_mem
`default_nettype wire
